// ---- core/psf_status_top.sv ----
// Purpose: Program status word with flag update and bank select
// Assumes: Datapath and APB share pclk; acc_value is same-domain
// Notes:   Zero-wait APB slave; unmapped addresses answer pslverr
//
// Operation
// RULE_01: Bank bits place registers in four banks
// RULE_02: Add overflow: carry from one of bits 6,7
// RULE_03: Subtract overflow: borrow into one of 6,7
// RULE_04: Multiply overflow when product exceeds 255
// RULE_05: Divide clears overflow; zero divisor sets
// RULE_06: Parity flag is odd count of accumulator ones
// RULE_07: User flag one is plain software storage
// RULE_08: User flag zero untouched by instructions
// RULE_09: Each instruction changes only its listed flags
// RULE_10: Software write beats same-cycle instruction updates
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module psf_status_top
  import psf_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [PSF_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    ex_valid,
  input  wire psf_op_t                 ex_op,
  input  wire logic [7:0]              ex_opnd_a,
  input  wire logic [7:0]              ex_opnd_b,
  input  wire logic                    ex_carry_val,
  input  wire logic [7:0]              acc_value,
  output var  logic [7:0]              status_word,
  output var  logic [PSF_BANK_ADDR_W-1:0] bank_base_addr
);

  // ==========================================================
  // Registers
  logic [7:0]                 psw_ff;
  logic [7:0]                 nxt_psw;
  logic [PSF_BANK_ADDR_W-1:0] bank_base_ff;
  logic [PSF_BANK_ADDR_W-1:0] nxt_bank_base;
  logic [31:0]                prdata_ff;
  logic [31:0]                nxt_prdata;
  logic                       pready_ff;
  logic                       nxt_pready;
  logic                       pslverr_ff;
  logic                       nxt_pslverr;
  logic                       par_odd;

  // ==========================================================
  // APB decode
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable & pready_ff;
  wire hit_psw   = (paddr == PSF_ADDR_STATUS);
  wire hit_bank  = (paddr == PSF_ADDR_BANK);
  wire hit_any   = hit_psw | hit_bank;
  // Status word sits in byte lane 0
  wire psw_wr    = access_ph & pwrite & hit_psw & pstrb[0];

  // Answer one cycle after setup
  assign nxt_pready  = setup_ph;
  assign nxt_pslverr = setup_ph & ~hit_any;

  // Read data captured at the setup edge
  assign nxt_prdata = !setup_ph ? 32'h0000_0000 :
                      hit_psw   ? {24'h00_0000, psw_ff} :
                      hit_bank  ? {27'h000_0000, bank_base_ff} :
                                  32'h0000_0000;

  // ==========================================================
  // Flag calculator and parity
  psf_flag_if fi ();

  assign fi.op        = ex_valid ? ex_op : PSF_OP_NONE;
  assign fi.opnd_a    = ex_opnd_a;
  assign fi.opnd_b    = ex_opnd_b;
  assign fi.carry_in  = psw_ff[PSF_POS_CY];
  assign fi.carry_val = ex_carry_val;

  psf_flag_calc u_calc (
    .fi (fi.calc)
  );

  psf_parity #(
    .WIDTH (8)
  ) u_par (
    .data (acc_value),
    .odd  (par_odd)
  );

  // ==========================================================
  // Next status word
  wire upd_cy = fi.upd_cy;
  wire upd_ov = fi.upd_ov;
  wire upd_ac = fi.upd_ac;

  // Software write wins; flags commit with the result edge
  assign nxt_psw[PSF_POS_CY] = psw_wr ? pwdata[PSF_POS_CY] :  // RULE_10
                               upd_cy ? fi.new_cy :  // RULE_09
                                        psw_ff[PSF_POS_CY];
  assign nxt_psw[PSF_POS_AC] = psw_wr ? pwdata[PSF_POS_AC] :  // RULE_10
                               upd_ac ? fi.new_ac :  // RULE_09
                                        psw_ff[PSF_POS_AC];
  assign nxt_psw[PSF_POS_OV] = psw_wr ? pwdata[PSF_POS_OV] :  // RULE_10
                               upd_ov ? fi.new_ov :  // RULE_09
                                        psw_ff[PSF_POS_OV];
  // User flags change only by software
  assign nxt_psw[PSF_POS_F0] = psw_wr ? pwdata[PSF_POS_F0] :  // RULE_08
                                        psw_ff[PSF_POS_F0];
  assign nxt_psw[PSF_POS_F1] = psw_wr ? pwdata[PSF_POS_F1] :  // RULE_07
                                        psw_ff[PSF_POS_F1];
  // Bank select bits
  assign nxt_psw[PSF_POS_BS_HI] = psw_wr ? pwdata[PSF_POS_BS_HI] :
                                           psw_ff[PSF_POS_BS_HI];
  assign nxt_psw[PSF_POS_BS_LO] = psw_wr ? pwdata[PSF_POS_BS_LO] :
                                           psw_ff[PSF_POS_BS_LO];
  // Parity is read-only and tracks the accumulator
  assign nxt_psw[PSF_POS_PAR] = par_odd;  // RULE_06

  // Bank base: bank number times eight registers
  assign nxt_bank_base = {nxt_psw[PSF_POS_BS_HI:PSF_POS_BS_LO],  // RULE_01
                          {PSF_BANK_REG_LOG2{1'b0}}};

  // ==========================================================
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_ff       <= PSF_RST_STATUS;
      bank_base_ff <= PSF_RST_BANK_BASE;
    end else begin
      psw_ff       <= nxt_psw;
      bank_base_ff <= nxt_bank_base;
    end
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign status_word    = psw_ff;
  assign bank_base_addr = bank_base_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Independent overflow and aux-carry references
  wire       op_go   = ex_valid & ~psw_wr;
  wire       cy_now  = psw_ff[PSF_POS_CY];
  wire [7:0] sum8    = ex_opnd_a + ex_opnd_b
                     + {7'h00, (ex_op == PSF_OP_ADDC) & cy_now};
  wire [7:0] dif8    = ex_opnd_a - ex_opnd_b - {7'h00, cy_now};
  wire       ref_aov = (ex_opnd_a[7] == ex_opnd_b[7])
                     & (sum8[7] != ex_opnd_a[7]);
  wire       ref_sov = (ex_opnd_a[7] != ex_opnd_b[7])
                     & (dif8[7] != ex_opnd_a[7]);
  wire [4:0] nib5    = {1'b0, ex_opnd_a[3:0]} + {1'b0, ex_opnd_b[3:0]}
                     + {4'h0, (ex_op == PSF_OP_ADDC) & cy_now};
  wire       ref_aac = (nib5 > 5'h0F);
  wire       ref_mov = (ex_opnd_a != 8'h00) & (ex_opnd_b != 8'h00)
                     & ({8'h00, ex_opnd_a} * {8'h00, ex_opnd_b}
                        > 16'h00FF);

  // Bank base follows the select bits
  chk_bank_base_map: assert property ( // RULE_01
    bank_base_ff[PSF_BANK_ADDR_W-1:PSF_BANK_REG_LOG2]
      == psw_ff[PSF_POS_BS_HI:PSF_POS_BS_LO]
    && bank_base_ff[PSF_BANK_REG_LOG2-1:0] == 3'h0)
    else $error("bank base does not match select bits");

  // Add overflow against the sign rule
  chk_add_ov_flag: assert property ( // RULE_02
    op_go && (ex_op == PSF_OP_ADD || ex_op == PSF_OP_ADDC)
    |=> psw_ff[PSF_POS_OV] == $past(ref_aov))
    else $error("add overflow flag wrong");

  // Subtract overflow against the sign rule
  chk_subb_ov_flag: assert property ( // RULE_03
    op_go && ex_op == PSF_OP_SUBB
    |=> psw_ff[PSF_POS_OV] == $past(ref_sov))
    else $error("subtract overflow flag wrong");

  // Multiply overflow and carry cleared
  chk_mul_flags: assert property ( // RULE_04
    op_go && ex_op == PSF_OP_MUL
    |=> psw_ff[PSF_POS_OV] == $past(ref_mov) && !psw_ff[PSF_POS_CY])
    else $error("multiply flags wrong");

  // Divide overflow only on a zero divisor
  chk_div_flags: assert property ( // RULE_05
    op_go && ex_op == PSF_OP_DIV
    |=> psw_ff[PSF_POS_OV] == ($past(ex_opnd_b) == 8'h00)
        && !psw_ff[PSF_POS_CY])
    else $error("divide flags wrong");

  // Parity tracks accumulator one cycle later
  chk_parity_flag: assert property ( // RULE_06
    1'b1 |=> psw_ff[PSF_POS_PAR] == ^$past(acc_value))
    else $error("parity flag wrong");

  // User flag one held without a software write
  chk_user_one: assert property ( // RULE_07
    !psw_wr |=> $stable(psw_ff[PSF_POS_F1]))
    else $error("user flag one changed by hardware");

  // User flag zero held through instructions
  chk_user_zero: assert property ( // RULE_08
    !psw_wr ##1 !psw_wr |=> $stable(psw_ff[PSF_POS_F0]))
    else $error("user flag zero changed by hardware");

  // Carry-only ops leave overflow and aux carry
  chk_carry_only: assert property ( // RULE_09
    op_go && (ex_op == PSF_OP_CLRC || ex_op == PSF_OP_SETC
              || ex_op == PSF_OP_CYLD)
    |=> psw_ff[PSF_POS_CY] == ($past(ex_op) == PSF_OP_SETC
          || ($past(ex_op) == PSF_OP_CYLD && $past(ex_carry_val)))
        && $stable(psw_ff[PSF_POS_OV]) && $stable(psw_ff[PSF_POS_AC]))
    else $error("carry-only op touched other flags");

  // Software write beats the same-cycle update
  chk_sw_write_wins: assert property ( // RULE_10
    psw_wr |=> psw_ff[7:1] == $past(pwdata[7:1]))
    else $error("software write lost to flag update");

  // Zero-wait answer follows each setup
  chk_apb_answer: assert property (
    setup_ph |=> pready_ff && pslverr_ff == !$past(hit_any)
    ##1 !pready_ff)
    else $error("apb answer timing wrong");

  // Read data is zero outside the answer cycle
  chk_rdata_idle: assert property (
    !pready_ff |-> prdata_ff == 32'h0000_0000)
    else $error("read data not zero while idle");

  // Error answer only stands with ready
  chk_err_ready: assert property (
    pslverr_ff |-> pready_ff)
    else $error("error answer without ready");

  // Bank base register ignores bus writes
  chk_bank_ro: assert property ( // RULE_01
    access_ph && pwrite && hit_bank |=> $stable(bank_base_ff))
    else $error("bank base changed by bus write");

  // Bank select bits held without a software write
  chk_bank_hold: assert property ( // RULE_01
    !psw_wr |=> $stable(psw_ff[PSF_POS_BS_HI:PSF_POS_BS_LO]))
    else $error("bank select changed by hardware");

  // Write without lane 0 strobe leaves the word
  chk_strobe_gate: assert property (
    access_ph && pwrite && hit_psw && !pstrb[0] && !ex_valid
    |=> $stable(psw_ff[7:1]))
    else $error("status word written without strobe");

  // Multiply and divide keep aux carry
  chk_muldiv_aux: assert property ( // RULE_09
    op_go && (ex_op == PSF_OP_MUL || ex_op == PSF_OP_DIV)
    |=> $stable(psw_ff[PSF_POS_AC]))
    else $error("multiply or divide touched aux carry");

  // Add aux carry from the low nibble
  chk_add_aux: assert property ( // RULE_09
    op_go && (ex_op == PSF_OP_ADD || ex_op == PSF_OP_ADDC)
    |=> psw_ff[PSF_POS_AC] == $past(ref_aac))
    else $error("add aux carry wrong");

  // Idle datapath leaves the arithmetic flags
  chk_idle_hold: assert property ( // RULE_09
    !ex_valid && !psw_wr
    |=> $stable(psw_ff[PSF_POS_CY:PSF_POS_AC])
        && $stable(psw_ff[PSF_POS_OV]))
    else $error("flags changed with no request");

endmodule

`default_nettype wire

// ---- core/psf_pkg.sv ----
// Purpose: Shared constants and types for the status flag block
// Assumes: APB slave with 32-bit data, byte addresses
// Notes:   Status word bit layout and flag-op encodings live here
`default_nettype none

package psf_pkg;

  // ==========================================================
  // Register map
  localparam int          PSF_ADDR_W       = 12;
  localparam logic [11:0] PSF_ADDR_STATUS  = 12'h000;
  localparam logic [11:0] PSF_ADDR_BANK    = 12'h004;

  // ==========================================================
  // Status word fields
  localparam int          PSF_POS_CY       = 7;
  localparam int          PSF_POS_AC       = 6;
  localparam int          PSF_POS_F0       = 5;
  localparam int          PSF_POS_BS_HI    = 4;
  localparam int          PSF_POS_BS_LO    = 3;
  localparam int          PSF_POS_OV       = 2;
  localparam int          PSF_POS_F1       = 1;
  localparam int          PSF_POS_PAR      = 0;
  localparam logic [7:0]  PSF_RST_STATUS   = 8'h00;

  // ==========================================================
  // Working register banks: eight registers per bank
  localparam int          PSF_BANK_REG_LOG2 = 3;
  localparam int          PSF_BANK_ADDR_W   = 5;
  localparam logic [4:0]  PSF_RST_BANK_BASE = 5'h00;

  // ==========================================================
  // Flag operations requested by the execution datapath
  typedef enum logic [3:0] {
    PSF_OP_NONE = 4'h0,
    PSF_OP_ADD  = 4'h1,
    PSF_OP_ADDC = 4'h2,
    PSF_OP_SUBB = 4'h3,
    PSF_OP_MUL  = 4'h4,
    PSF_OP_DIV  = 4'h5,
    PSF_OP_CLRC = 4'h6,
    PSF_OP_SETC = 4'h7,
    PSF_OP_CYLD = 4'h8
  } psf_op_t;

endpackage

`default_nettype wire

// ---- core/psf_flag_if.sv ----
// Purpose: Carries operands and flag results between core and calculator
// Assumes: Purely combinational path inside one clock domain
// Notes:   upd_* mark which flags the operation changes
`timescale 1ns/1ps
`default_nettype none

interface psf_flag_if;
  import psf_pkg::*;

  // ==========================================================
  // Request and result bundle
  psf_op_t    op;
  logic [7:0] opnd_a;
  logic [7:0] opnd_b;
  logic       carry_in;
  logic       carry_val;
  logic       new_cy;
  logic       new_ov;
  logic       new_ac;
  logic       upd_cy;
  logic       upd_ov;
  logic       upd_ac;

  modport core (output op, opnd_a, opnd_b, carry_in, carry_val,
                input  new_cy, new_ov, new_ac, upd_cy, upd_ov, upd_ac);
  modport calc (input  op, opnd_a, opnd_b, carry_in, carry_val,
                output new_cy, new_ov, new_ac, upd_cy, upd_ov, upd_ac);
endinterface

`default_nettype wire

// ---- core/psf_flag_calc.sv ----
// Purpose: Computes carry, overflow and aux-carry for one flag operation
// Assumes: Operands are stable for the cycle the op is presented
// Notes:   Pure combinational logic, no state
`timescale 1ns/1ps
`default_nettype none

module psf_flag_calc
  import psf_pkg::*;
(
  psf_flag_if.calc fi
);

  // ==========================================================
  // Adder and subtractor slices
  wire       cin_add = (fi.op == PSF_OP_ADDC) & fi.carry_in;
  wire [8:0] add9 = {1'b0, fi.opnd_a} + {1'b0, fi.opnd_b}
                  + {8'h00, cin_add};
  wire [7:0] add7 = {1'b0, fi.opnd_a[6:0]} + {1'b0, fi.opnd_b[6:0]}
                  + {7'h00, cin_add};
  wire [4:0] add4 = {1'b0, fi.opnd_a[3:0]} + {1'b0, fi.opnd_b[3:0]}
                  + {4'h0, cin_add};
  wire [8:0] sub9 = {1'b0, fi.opnd_a} - {1'b0, fi.opnd_b}
                  - {8'h00, fi.carry_in};
  wire [7:0] sub7 = {1'b0, fi.opnd_a[6:0]} - {1'b0, fi.opnd_b[6:0]}
                  - {7'h00, fi.carry_in};
  wire [4:0] sub4 = {1'b0, fi.opnd_a[3:0]} - {1'b0, fi.opnd_b[3:0]}
                  - {4'h0, fi.carry_in};
  wire [15:0] prod = {8'h00, fi.opnd_a} * {8'h00, fi.opnd_b};

  // Overflow is set when exactly one of bit 6 and bit 7 carries
  wire add_ov = add7[7] ^ add9[8];  // RULE_02
  // Borrow into exactly one of bit 6 and bit 7
  wire sub_ov = sub7[7] ^ sub9[8];  // RULE_03
  wire mul_ov = |prod[15:8];  // RULE_04
  wire div_ov = (fi.opnd_b == 8'h00);  // RULE_05

  // ==========================================================
  // Flag selection per operation
  always_comb begin
    fi.new_cy = 1'b0;
    fi.new_ov = 1'b0;
    fi.new_ac = 1'b0;
    fi.upd_cy = 1'b0;
    fi.upd_ov = 1'b0;
    fi.upd_ac = 1'b0;
    case (fi.op)
      PSF_OP_ADD, PSF_OP_ADDC: begin
        {fi.upd_cy, fi.upd_ov, fi.upd_ac} = 3'h7;  // RULE_09
        fi.new_cy = add9[8];
        fi.new_ov = add_ov;
        fi.new_ac = add4[4];
      end
      PSF_OP_SUBB: begin
        {fi.upd_cy, fi.upd_ov, fi.upd_ac} = 3'h7;  // RULE_09
        fi.new_cy = sub9[8];
        fi.new_ov = sub_ov;
        fi.new_ac = sub4[4];
      end
      PSF_OP_MUL: begin
        {fi.upd_cy, fi.upd_ov} = 2'h3;  // RULE_09
        fi.new_ov = mul_ov;
      end
      PSF_OP_DIV: begin
        {fi.upd_cy, fi.upd_ov} = 2'h3;  // RULE_09
        fi.new_ov = div_ov;
      end
      PSF_OP_CLRC: fi.upd_cy = 1'b1;  // RULE_09
      PSF_OP_SETC: begin
        fi.upd_cy = 1'b1;  // RULE_09
        fi.new_cy = 1'b1;
      end
      PSF_OP_CYLD: begin
        fi.upd_cy = 1'b1;  // RULE_09
        fi.new_cy = fi.carry_val;
      end
      default: fi.upd_cy = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ---- core/psf_parity.sv ----
// Purpose: Odd-ones detector over the accumulator value
// Assumes: Accumulator value comes from logic on the same clock
// Notes:   Result is 1 when the count of one bits is odd
`timescale 1ns/1ps
`default_nettype none

module psf_parity #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] data,
  output var  logic             odd
);

  // ==========================================================
  // XOR chain, one stage per bit
  logic [WIDTH:0] chain;

  assign chain[0] = 1'b0;
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign chain[i+1] = chain[i] ^ data[i];  // RULE_06
  end
  assign odd = chain[WIDTH];

endmodule

`default_nettype wire

// ---- bench/psf_core_model.sv ----
// Purpose: Behavioural execution datapath feeding flag requests
// Assumes: Requests change right after a rising edge of pclk
// Notes:   Operands are inverted while idle so stale values never match
`timescale 1ns/1ps
`default_nettype none

module psf_core_model
  import psf_pkg::*;
(
  input  wire logic       pclk,
  output var  logic       ex_valid,
  output var  psf_op_t    ex_op,
  output var  logic [7:0] ex_opnd_a,
  output var  logic [7:0] ex_opnd_b,
  output var  logic       ex_carry_val,
  output var  logic [7:0] acc_value
);
  // ==========================================================
  // Idle state from time zero
  initial begin
    ex_valid = 1'b0;
    ex_op = PSF_OP_NONE;
    ex_opnd_a = 8'h00;
    ex_opnd_b = 8'h00;
    ex_carry_val = 1'b0;
    acc_value = 8'h00;
  end

  // One request for one edge, after gap idle cycles (slow answer)
  task automatic run(input psf_op_t op, input logic [7:0] a,
                     input logic [7:0] b, input logic cv,
                     input logic [7:0] acc, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    ex_valid <= 1'b1;
    ex_op <= op;
    ex_opnd_a <= a;
    ex_opnd_b <= b;
    ex_carry_val <= cv;
    acc_value <= acc;
    @(posedge pclk);
    ex_valid <= 1'b0;
    ex_op <= PSF_OP_NONE;
    ex_opnd_a <= ~a;
    ex_opnd_b <= ~b;
    ex_carry_val <= ~cv;
  endtask
endmodule

`default_nettype wire

// ---- bench/program_status_flags_tb_top.sv ----
// Purpose: Self-checking bench for the status flag block
// Assumes: Zero-wait APB slave; datapath model drives flag requests
// Notes:   Notes queued per transfer, compared when pready appears
`timescale 1ns/1ps
`default_nettype none

module program_status_flags_tb_top;
  import psf_pkg::*;

  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [PSF_ADDR_W-1:0]      paddr;
  logic [31:0]                pwdata;
  logic [3:0]                 pstrb;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       ex_valid;
  psf_op_t                    ex_op;
  logic [7:0]                 ex_opnd_a;
  logic [7:0]                 ex_opnd_b;
  logic                       ex_carry_val;
  logic [7:0]                 acc_value;
  logic [7:0]                 status_word;
  logic [PSF_BANK_ADDR_W-1:0] bank_base_addr;
  logic [33:0]                exp_q[$];
  logic [33:0]                note;
  logic [7:0]                 exp_psw;
  logic [7:0]                 acc_now;
  logic [31:0]                lfsr;
  logic [31:0]                rv;
  logic [19:0]                tab [6];
  int                         fails;
  int                         n_checks;

  // ==========================================================
  // Design, datapath model and clock
  psf_status_top i_psf_status_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ex_valid(ex_valid), .ex_op(ex_op),
    .ex_opnd_a(ex_opnd_a), .ex_opnd_b(ex_opnd_b),
    .ex_carry_val(ex_carry_val), .acc_value(acc_value),
    .status_word(status_word), .bank_base_addr(bank_base_addr));
  psf_core_model i_psf_core_model (.pclk(pclk), .ex_valid(ex_valid),
    .ex_op(ex_op), .ex_opnd_a(ex_opnd_a), .ex_opnd_b(ex_opnd_b),
    .ex_carry_val(ex_carry_val), .acc_value(acc_value));

  always #5 pclk = ~pclk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Expected status word after one flag request
  function automatic logic [7:0] flags(psf_op_t op, logic [7:0] a,
                                       logic [7:0] b, logic cv,
                                       logic [7:0] p);
    logic [8:0] s7;
    logic [7:0] s6;
    logic [4:0] s3;
    logic       ci;
    ci = (op == PSF_OP_ADD) ? 1'b0 : p[7];
    flags = p;
    if (op == PSF_OP_SUBB) begin
      s7 = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      s6 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, ci};
      s3 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    end else begin
      s7 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      s6 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
      s3 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    end
    case (op)
      PSF_OP_ADD, PSF_OP_ADDC, PSF_OP_SUBB: begin
        flags[7] = s7[8];
        flags[6] = s3[4];
        flags[2] = s7[8] ^ s6[7];
      end
      PSF_OP_MUL: begin
        flags[7] = 1'b0;
        flags[2] = ({8'h00, a} * {8'h00, b}) > 16'h00FF;
      end
      PSF_OP_DIV: begin
        flags[7] = 1'b0;
        flags[2] = (b == 8'h00);
      end
      PSF_OP_CLRC: flags[7] = 1'b0;
      PSF_OP_SETC: flags[7] = 1'b1;
      PSF_OP_CYLD: flags[7] = cv;
      default: flags = p;
    endcase
  endfunction

  task automatic close_out();
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic err);
    exp_q.push_back({1'b1, err, 32'h0000_0000});
    apb(1'b1, a, {rv[31:8], d}, s);
  endtask

  task automatic rd(input logic [11:0] a, input logic err,
                    input logic [31:0] d);
    exp_q.push_back({1'b0, err, d});
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  task automatic rd_psw();
    rd(PSF_ADDR_STATUS, 1'b0, {24'h0, exp_psw[7:1], ^acc_now});
    @(negedge pclk);
    n_checks++;
    if (status_word !== {exp_psw[7:1], ^acc_now}) begin
      fails++;
      $display("[ERR] status_word exp %h seen %h",
               {exp_psw[7:1], ^acc_now}, status_word);
    end
  endtask

  task automatic rd_bank();
    rd(PSF_ADDR_BANK, 1'b0, {27'h0, exp_psw[4:3], 3'h0});
    @(negedge pclk);
    n_checks++;
    if (bank_base_addr !== {exp_psw[4:3], 3'h0}) begin
      fails++;
      $display("[ERR] bank_base_addr exp %h seen %h",
               {exp_psw[4:3], 3'h0}, bank_base_addr);
    end
  endtask

  task automatic op(input psf_op_t o, input logic [7:0] a,
                    input logic [7:0] b, input logic cv);
    exp_psw = flags(o, a, b, cv, exp_psw);
    rv = rnd();
    acc_now = rv[15:8];
    i_psf_core_model.run(o, a, b, cv, acc_now, int'(rv[1:0]));
  endtask

  // ==========================================================
  // Watcher: oldest note against each APB answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n_checks++;
      if (pslverr !== note[32] || (!note[33] && prdata !== note[31:0]))
      begin
        fails++;
        $display("[ERR] apb answer exp %h seen %h", note[32:0],
                 {pslverr, prdata});
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    lfsr = 32'h2E9D;
    rv = 32'h0000_0000;
    exp_psw = PSF_RST_STATUS;
    acc_now = 8'h00;
    fails = 0;
    n_checks = 0;
    tab = '{{4'h4, 8'h10, 8'h10}, {4'h4, 8'h0F, 8'h11},
            {4'h5, 8'h33, 8'h00}, {4'h5, 8'h33, 8'h07},
            {4'h1, 8'h7F, 8'h01}, {4'h3, 8'h80, 8'h01}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_psw();
    for (int b = 0; b < 4; b++) begin
      rv = rnd();
      exp_psw = (rv[7:0] & 8'hE7) | 8'(b << 3);
      wr(PSF_ADDR_STATUS, exp_psw, 4'hF, 1'b0);
      rd_psw();
      rd_bank();
    end
    wr(PSF_ADDR_STATUS, ~exp_psw, 4'h0, 1'b0);
    wr(PSF_ADDR_BANK, 8'hFF, 4'hF, 1'b0);
    rd_bank();
    rd(12'h008, 1'b1, 32'h0000_0000);
    wr(12'h00C, 8'h5A, 4'hF, 1'b1);
    rd_psw();
    for (int k = 0; k < 6; k++) begin
      op(psf_op_t'(tab[k][19:16]), tab[k][15:8], tab[k][7:0], 1'b1);
      rd_psw();
    end
    for (int r = 0; r < 8; r++) begin
      for (int o = 0; o < 9; o++) begin
        rv = rnd();
        op(psf_op_t'(o), rv[7:0], rv[23:16], rv[30]);
        rd_psw();
      end
    end
    // Same-edge software write against an add that sets carry, aux carry and overflow
    fork
      wr(PSF_ADDR_STATUS, 8'h20, 4'h1, 1'b0);
      begin
        @(posedge pclk);
        i_psf_core_model.run(PSF_OP_ADD, 8'h88, 8'h88, 1'b0, acc_now, 0);
      end
    join
    exp_psw = 8'h20;
    rd_psw();
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) begin
      fails++;
      $display("[ERR] pending answers exp 0 seen %0d", exp_q.size());
    end
    close_out();
  end
endmodule

`default_nettype wire
